// ### cmpc_bus_partner.sv
// cmpc_bus_partner: an older bus peripheral that counts fetch marks
// assumes: strobe is active low and registered by the block under test
`timescale 1ns/1ns
module cmpc_bus_partner (
	// clock and clear
	input wire logic clk_sys_i,
	input wire logic clear_i,
	// strobe seen on the bus
	input wire logic fetch_cycle_strobe_n_i,
	// observed count
	output logic [7:0] fetch_marks_o
);
	logic fetch_q;
	// counts falling edges only, so a strobe held low is one mark
	always_ff @(posedge clk_sys_i) begin
		fetch_q <= fetch_cycle_strobe_n_i;
		if (clear_i)
			fetch_marks_o <= 8'h00;
		else if (fetch_q && !fetch_cycle_strobe_n_i)
			fetch_marks_o <= fetch_marks_o + 8'h01;
	end
endmodule // cmpc_bus_partner

// ### cmpc_pkg.sv
// cmpc_pkg: constants and carrier types for the mode and power control block
// assumes: single system clock, registers reached over the core's i/o strobes
package cmpc_pkg;

	// ****************************************
	// register map and fields
	// ****************************************
	localparam logic [7:0] MODE_CONTROL_REG_ADDR = 8'h3E;
	localparam int FETCH_MARKER_ENABLE_BIT = 7;
	localparam int ONE_SHOT_FETCH_MARKER_BIT = 6;
	localparam int IO_TIMING_SELECT_BIT = 5;
	localparam logic [7:0] MODE_CONTROL_RESET = 8'hE0;
	localparam logic [7:0] MODE_CONTROL_RSVD = 8'h1F;
	localparam int PERIPHERAL_HALT_BIT = 5;
	localparam int CPU_CTRL_BIT_A = 3;
	localparam int CPU_CTRL_BIT_B = 6;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [2:0] {
		CMPC_NORMAL = 3'b000,
		CMPC_HALT = 3'b001,
		CMPC_SLEEP = 3'b010,
		CMPC_SYS_STOP = 3'b011
	} cmpc_state_t;

	// cycle kind reported by the core for the coming machine cycle
	typedef struct packed {
		logic opcode_fetch;
		logic irq0_ack;
		logic nmi_ack_first;
		logic return_from_interrupt_op_fetch;
		logic io_cycle;
		logic t2;
	} cmpc_cycle_t;

	// wake sources, each already anded with its own individual enable
	typedef struct packed {
		logic nmi;
		logic ext_irq;
		logic onchip_irq;
	} cmpc_wake_t;

endpackage

// ### cmpc_top.sv
// cmpc_top: operating mode control register, halt/sleep power states,
// and the shared serial-receive / clear-to-send pin select
// assumes: the core reports each machine cycle on cycle_i, inputs from pins
// arrive unsynchronised, bus ownership is known on ext_master_i
`timescale 1ns/1ns
module cmpc_top #(
	parameter int ADDR_W = 20
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic srst_i,
	// i/o register access from the core
	input wire logic [7:0] io_addr_i,
	input wire logic io_wr_i,
	input wire logic io_rd_i,
	input wire logic [7:0] io_wdata_i,
	output logic [7:0] io_rdata_o,
	// core cycle status and instructions
	input wire cmpc_pkg::cmpc_cycle_t cycle_i,
	input wire logic halt_op_i,
	input wire logic sleep_op_i,
	input wire logic global_irq_flag_i,
	input wire logic [7:0] io_control_register_i,
	input wire logic [7:0] cpu_control_register_i,
	input wire logic [ADDR_W-1:0] core_addr_i,
	input wire logic [3:0] core_ctrl_n_i,
	// wake sources and bus ownership (pins)
	input wire cmpc_pkg::cmpc_wake_t wake_i,
	input wire logic ext_master_i,
	// shared pin and its two consumers
	input wire logic shared_pin_i,
	input wire logic clear_to_send_select_i,
	output logic clocked_serial_rx_in_o,
	output logic clear_to_send_ch1_o,
	// bus strobes, status, power
	output logic fetch_cycle_strobe_n_o,
	output logic io_request_strobe_n_o,
	output logic io_read_strobe_n_o,
	output logic machine_cycle_flag_o,
	output logic halt_n_o,
	output logic [ADDR_W-1:0] addr_o,
	output logic [3:0] ctrl_n_o,
	output logic core_clk_en_o,
	output logic dma_clk_en_o,
	output logic refresh_en_o,
	output logic periph_run_o,
	output logic irq_take_o,
	output logic resume_next_o,
	output logic return_from_interrupt_op_refetch_o,
	output logic [1:0] fetch_clocks_o
);
	import cmpc_pkg::*;

	// ****************************************
	// input synchronisers
	// ****************************************
	cmpc_wake_t wake_s1, wake_s2;
	logic pin_s1, pin_s2, grant_s1, grant_s2;
	always_ff @(posedge clk_sys_i) begin
		wake_s1 <= wake_i;
		wake_s2 <= wake_s1;
		pin_s1 <= shared_pin_i;
		pin_s2 <= pin_s1;
		grant_s1 <= ext_master_i;
		grant_s2 <= grant_s1;
	end

	// ****************************************
	// mode control register
	// ****************************************
	logic fetch_marker_enable, one_shot_pend, io_timing_select;
	wire reg_hit = (io_addr_i == MODE_CONTROL_REG_ADDR);
	wire reg_wr = io_wr_i && reg_hit;
	wire reg_rd = io_rd_i && reg_hit;
	wire fetch_now = cycle_i.opcode_fetch;
	// one-shot bit reads as 1 always; reserved bits read 1
	wire [7:0] reg_view = {fetch_marker_enable, 1'b1, io_timing_select,
		MODE_CONTROL_RSVD[4:0]};
	wire [7:0] next_rdata = reg_rd ? reg_view : 8'h00;
	// a write of 0 arms one fetch; consumed by that fetch, arming wins
	wire next_one_shot = (reg_wr && !io_wdata_i[ONE_SHOT_FETCH_MARKER_BIT])
		|| (one_shot_pend && !fetch_now);

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			fetch_marker_enable <= MODE_CONTROL_RESET[FETCH_MARKER_ENABLE_BIT];
			io_timing_select <= MODE_CONTROL_RESET[IO_TIMING_SELECT_BIT];
			one_shot_pend <= 1'b0;
		end else begin
			if (reg_wr) begin
				fetch_marker_enable <= io_wdata_i[FETCH_MARKER_ENABLE_BIT];
				io_timing_select <= io_wdata_i[IO_TIMING_SELECT_BIT];
			end
			one_shot_pend <= next_one_shot;
		end
	end

	// ****************************************
	// power state machine
	// ****************************************
	cmpc_state_t state, next_state;
	wire periph_halt = io_control_register_i[PERIPHERAL_HALT_BIT];
	// stopped peripherals cannot raise a wake request from system stop
	wire onchip_wake = wake_s2.onchip_irq && !periph_halt;
	wire any_wake_halt = wake_s2.nmi || wake_s2.ext_irq ||
		wake_s2.onchip_irq;
	wire any_wake_sleep = wake_s2.nmi || wake_s2.ext_irq ||
		((state == CMPC_SYS_STOP) ? onchip_wake : wake_s2.onchip_irq);
	// software must clear these bits before sleep; otherwise sleep is ignored
	wire sleep_ok = !cpu_control_register_i[CPU_CTRL_BIT_A] &&
		!cpu_control_register_i[CPU_CTRL_BIT_B];
	wire in_sleep = (state == CMPC_SLEEP) || (state == CMPC_SYS_STOP);
	wire wake_now = ((state == CMPC_HALT) && any_wake_halt) ||
		(in_sleep && any_wake_sleep);

	always_comb begin
		next_state = state;
		unique case (state)
			CMPC_NORMAL: begin
				if (halt_op_i)
					next_state = CMPC_HALT;
				else if (sleep_op_i && sleep_ok)
					next_state = periph_halt ? CMPC_SYS_STOP : CMPC_SLEEP;
			end
			CMPC_HALT: begin
				if (any_wake_halt)
					next_state = CMPC_NORMAL;
			end
			CMPC_SLEEP, CMPC_SYS_STOP: begin
				if (any_wake_sleep)
					next_state = CMPC_NORMAL;
			end
			default: next_state = CMPC_NORMAL;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i)
			state <= CMPC_NORMAL;
		else
			state <= next_state;
	end

	// ****************************************
	// strobe decode
	// ****************************************
	// return op: once with marker enabled, refetched otherwise; the strobe is not driven for the refetch
	wire return_from_interrupt_op_again = cycle_i.return_from_interrupt_op_fetch && !fetch_marker_enable;
	wire mark_cycle = (fetch_marker_enable && (cycle_i.opcode_fetch ||
		cycle_i.irq0_ack || cycle_i.nmi_ack_first)) ||
		(one_shot_pend && fetch_now);
	// legacy timing goes active only from t2; alternate from t1
	wire io_go = cycle_i.io_cycle &&
		(io_timing_select || cycle_i.t2);
	wire sleep_drive = in_sleep && !grant_s2;
	wire next_strobe = (state == CMPC_HALT) ? 1'b0 :
		sleep_drive ? 1'b1 : !mark_cycle;
	wire next_halt = !(next_state != CMPC_NORMAL);
	// status flag: low in halt, high in sleep, low on first fetch otherwise
	wire next_flag = (state == CMPC_HALT) ? 1'b0 :
		in_sleep ? 1'b1 : !cycle_i.opcode_fetch;
	wire [1:0] next_clocks = fetch_marker_enable ? 2'd3 : 2'd0;

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			io_rdata_o <= 8'h00;
			fetch_cycle_strobe_n_o <= 1'b1;
			io_request_strobe_n_o <= 1'b1;
			io_read_strobe_n_o <= 1'b1;
			machine_cycle_flag_o <= 1'b1;
			halt_n_o <= 1'b1;
			addr_o <= '0;
			ctrl_n_o <= 4'hF;
			core_clk_en_o <= 1'b1;
			dma_clk_en_o <= 1'b1;
			refresh_en_o <= 1'b1;
			periph_run_o <= 1'b1;
			irq_take_o <= 1'b0;
			resume_next_o <= 1'b0;
			return_from_interrupt_op_refetch_o <= 1'b0;
			fetch_clocks_o <= 2'd3;
			clocked_serial_rx_in_o <= 1'b1;
			clear_to_send_ch1_o <= 1'b1;
		end else begin
			io_rdata_o <= next_rdata;
			fetch_cycle_strobe_n_o <= next_strobe;
			io_request_strobe_n_o <= sleep_drive ? 1'b1 : !io_go;
			io_read_strobe_n_o <= sleep_drive ? 1'b1 : !(io_go && io_rd_i);
			machine_cycle_flag_o <= next_flag;
			halt_n_o <= next_halt;
			addr_o <= sleep_drive ? '1 : core_addr_i;
			ctrl_n_o <= sleep_drive ? 4'hF : core_ctrl_n_i;
			core_clk_en_o <= !in_sleep;
			dma_clk_en_o <= !in_sleep;
			refresh_en_o <= !in_sleep;
			periph_run_o <= !periph_halt;
			irq_take_o <= wake_now && global_irq_flag_i;
			resume_next_o <= wake_now && !global_irq_flag_i;
			return_from_interrupt_op_refetch_o <= return_from_interrupt_op_again;
			fetch_clocks_o <= next_clocks;
			// unselected function sees its idle level
			clocked_serial_rx_in_o <= clear_to_send_select_i ? 1'b1 : pin_s2;
			clear_to_send_ch1_o <= clear_to_send_select_i ? pin_s2 : 1'b1;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);

	mc_readback_a: assert property (io_rd_i && io_addr_i == 8'h3E |=>
		io_rdata_o[6] == 1'b1) else $error("one-shot bit read as 0");
	mc_decode_a: assert property (io_rd_i && io_addr_i != 8'h3E |=>
		io_rdata_o == 8'h00) else $error("unmapped read not zero");
	halt_pins_a: assert property (state == CMPC_HALT |=>
		!fetch_cycle_strobe_n_o && !machine_cycle_flag_o)
		else $error("halt pins not low");
	halt_out_a: assert property (next_state != CMPC_NORMAL |=> !halt_n_o)
		else $error("halt output not low");
	sleep_addr_a: assert property (in_sleep && !grant_s2 |=>
		addr_o == '1 && ctrl_n_o == 4'hF) else $error("sleep pins");
	sleep_clk_a: assert property (in_sleep |=> !core_clk_en_o && !refresh_en_o)
		else $error("clock not gated in sleep");
	oneshot_fire_a: assert property (reg_wr && !io_wdata_i[6] ##1
		fetch_now && state == CMPC_NORMAL |=> !fetch_cycle_strobe_n_o)
		else $error("one-shot strobe missing");
	legacy_io_a: assert property (!io_timing_select && cycle_i.io_cycle &&
		!cycle_i.t2 && !sleep_drive |=> io_request_strobe_n_o)
		else $error("legacy i/o strobe early");
	sys_stop_a: assert property (state == CMPC_SYS_STOP && !wake_s2.nmi &&
		!wake_s2.ext_irq && periph_halt |=> state == CMPC_SYS_STOP)
		else $error("stopped unit woke system");
	wake_plain_a: assert property (in_sleep && any_wake_sleep &&
		!global_irq_flag_i |=> resume_next_o && !irq_take_o)
		else $error("no plain resume");
	periph_a: assert property (periph_halt |=> !periph_run_o)
		else $error("peripherals not halted");

	halt_wake_c: cover property (state == CMPC_HALT ##1 state == CMPC_NORMAL);
	sleep_c: cover property (state == CMPC_SLEEP ##[1:20] state == CMPC_NORMAL);
	sys_stop_c: cover property (state == CMPC_SYS_STOP);
	oneshot_c: cover property (one_shot_pend && fetch_now);

endmodule // cmpc_top

// ### cmpc_top_test.sv
// cmpc_top_test: self-checking bench for the mode and power control block
// assumes: design outputs registered, inputs driven 10 ns after the edge
`timescale 1ns/1ns
module cmpc_top_test;
	import cmpc_pkg::*;
	logic clk_sys_i, srst_i, io_wr_i, io_rd_i, halt_op_i, sleep_op_i;
	logic global_irq_flag_i, ext_master_i, shared_pin_i;
	logic clear_to_send_select_i, clocked_serial_rx_in_o, clear_to_send_ch1_o;
	logic [7:0] io_addr_i, io_wdata_i, io_rdata_o, marks;
	logic [7:0] io_control_register_i, cpu_control_register_i;
	logic [19:0] core_addr_i, addr_o;
	logic [3:0] core_ctrl_n_i, ctrl_n_o;
	logic [1:0] fetch_clocks_o;
	cmpc_cycle_t cycle_i;
	cmpc_wake_t wake_i;
	logic fetch_cycle_strobe_n_o, io_request_strobe_n_o, io_read_strobe_n_o;
	logic machine_cycle_flag_o, halt_n_o, core_clk_en_o, dma_clk_en_o;
	logic refresh_en_o, periph_run_o, irq_take_o, resume_next_o;
	logic return_from_interrupt_op_refetch_o, s_res, s_irq;
	int fails, check_count, cyc;
	cmpc_top dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
		.io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
		.io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .cycle_i(cycle_i),
		.halt_op_i(halt_op_i), .sleep_op_i(sleep_op_i),
		.global_irq_flag_i(global_irq_flag_i),
		.io_control_register_i(io_control_register_i),
		.cpu_control_register_i(cpu_control_register_i),
		.core_addr_i(core_addr_i), .core_ctrl_n_i(core_ctrl_n_i),
		.wake_i(wake_i), .ext_master_i(ext_master_i),
		.shared_pin_i(shared_pin_i),
		.clear_to_send_select_i(clear_to_send_select_i),
		.clocked_serial_rx_in_o(clocked_serial_rx_in_o),
		.clear_to_send_ch1_o(clear_to_send_ch1_o),
		.fetch_cycle_strobe_n_o(fetch_cycle_strobe_n_o),
		.io_request_strobe_n_o(io_request_strobe_n_o),
		.io_read_strobe_n_o(io_read_strobe_n_o),
		.machine_cycle_flag_o(machine_cycle_flag_o), .halt_n_o(halt_n_o),
		.addr_o(addr_o), .ctrl_n_o(ctrl_n_o), .core_clk_en_o(core_clk_en_o),
		.dma_clk_en_o(dma_clk_en_o), .refresh_en_o(refresh_en_o),
		.periph_run_o(periph_run_o), .irq_take_o(irq_take_o),
		.resume_next_o(resume_next_o), .return_from_interrupt_op_refetch_o(return_from_interrupt_op_refetch_o),
		.fetch_clocks_o(fetch_clocks_o));
	cmpc_bus_partner bus (.clk_sys_i(clk_sys_i), .clear_i(srst_i),
		.fetch_cycle_strobe_n_i(fetch_cycle_strobe_n_o), .fetch_marks_o(marks));
	// ****************************************
	// shared tasks
	// ****************************************
	initial begin
		clk_sys_i = 1'b0;
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	task automatic step(input int n = 1);
		repeat (n) @(posedge clk_sys_i);
		#10;
	endtask
	task automatic chk(input logic [19:0] got, exp, input string m);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %0t %s", $time, m);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		io_addr_i = a;
		io_wdata_i = d;
		io_wr_i = 1'b1;
		step();
		io_wr_i = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, exp);
		io_addr_i = a;
		io_rd_i = 1'b1;
		step();
		io_rd_i = 1'b0;
		chk(io_rdata_o, exp, "read data");
	endtask
	task automatic cyc_kind(input logic [5:0] k);
		cycle_i = k;
		step();
		cycle_i = 6'h00;
	endtask
	// wake inputs pass a two-flop sync, so allow eight cycles
	task automatic wake(input logic [2:0] w);
		wake_i = w;
		s_res = 1'b0;
		s_irq = 1'b0;
		for (int i = 0; i < 8 && halt_n_o !== 1'b1; i++) begin
			step();
			s_res |= resume_next_o;
			s_irq |= irq_take_o;
		end
		wake_i = 3'h0;
		step(3);
	endtask
	task automatic power_op(input bit sleep);
		if (sleep)
			sleep_op_i = 1'b1;
		else
			halt_op_i = 1'b1;
		step();
		sleep_op_i = 1'b0;
		halt_op_i = 1'b0;
		step();
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 2000) begin
			fails++;
			end_sim();
		end
	end
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		chk(halt_n_o, 1'b1, "halt idle");
		chk(fetch_clocks_o, 2'h3, "fetch clocks");
		chk(clocked_serial_rx_in_o, 1'b0, "rx follows pin");
		clear_to_send_select_i = 1'b1;
		step(4);
		chk(clear_to_send_ch1_o, 1'b0, "cts follows pin");
		clear_to_send_select_i = 1'b0;
		step(4);
		chk(clear_to_send_ch1_o, 1'b1, "cts idle");
		rd(8'h3E, 8'hFF);
		rd(8'h3D, 8'h00);
		$display("test reset done");
	endtask
	task automatic t_marker();
		for (int k = 0; k < 3; k++) begin
			cyc_kind(6'h20 >> k);
			chk(fetch_cycle_strobe_n_o, 1'b0, "mark low");
			step();
		end
		cyc_kind(6'h04);
		chk(return_from_interrupt_op_refetch_o, 1'b0, "single fetch");
		wr(8'h3E, 8'h60);
		cyc_kind(6'h20);
		chk(fetch_cycle_strobe_n_o, 1'b1, "no mark");
		chk(fetch_clocks_o, 2'h0, "normal timing");
		cyc_kind(6'h04);
		chk(return_from_interrupt_op_refetch_o, 1'b1, "refetch");
		$display("test marker done");
	endtask
	task automatic t_oneshot();
		logic [7:0] m0;
		m0 = marks;
		wr(8'h3E, 8'h20);
		rd(8'h3E, 8'h7F);
		cyc_kind(6'h20);
		step();
		cyc_kind(6'h20);
		step(2);
		chk(marks, m0 + 8'h01, "one mark only");
		wr(8'h3E, 8'h60);
		cyc_kind(6'h20);
		step(2);
		chk(marks, m0 + 8'h01, "writing one inert");
		wr(8'h3E, 8'h40);
		cyc_kind(6'h03);
		chk(io_request_strobe_n_o, 1'b0, "legacy io");
		wr(8'h3E, 8'hE0);
		$display("test oneshot done");
	endtask
	task automatic t_halt();
		power_op(1'b0);
		chk(halt_n_o, 1'b0, "halt low");
		chk(fetch_cycle_strobe_n_o, 1'b0, "halt mark");
		chk(machine_cycle_flag_o, 1'b0, "halt flag");
		chk({core_clk_en_o, dma_clk_en_o, refresh_en_o}, 3'h7, "runs");
		global_irq_flag_i = 1'b1;
		wake(3'h4);
		global_irq_flag_i = 1'b0;
		chk(halt_n_o, 1'b1, "halt left");
		chk({s_res, s_irq}, 2'h1, "irq taken on wake");
		$display("test halt done");
	endtask
	task automatic t_sleep();
		cpu_control_register_i = 8'h08;
		power_op(1'b1);
		chk(halt_n_o, 1'b1, "sleep refused");
		cpu_control_register_i = 8'h00;
		power_op(1'b1);
		chk({core_clk_en_o, dma_clk_en_o, refresh_en_o}, 3'h0, "gated");
		chk(periph_run_o, 1'b1, "periph run");
		chk(addr_o, 20'hFFFFF, "addr high");
		chk({ctrl_n_o, halt_n_o}, 5'h1E, "ctrl high");
		wake(3'h1);
		chk({halt_n_o, s_res, s_irq}, 3'h6, "silent wake");
		io_control_register_i = 8'h20;
		step(2);
		chk(periph_run_o, 1'b0, "periph stop");
		power_op(1'b1);
		wake(3'h1);
		chk(halt_n_o, 1'b0, "stopped source");
		wake(3'h2);
		chk(halt_n_o, 1'b1, "stop left");
		io_control_register_i = 8'h00;
		step(2);
		chk(periph_run_o, 1'b1, "periph resume");
		$display("test sleep done");
	endtask
	initial begin
		{io_wr_i, io_rd_i, halt_op_i, sleep_op_i, global_irq_flag_i} = 5'h00;
		{ext_master_i, shared_pin_i, clear_to_send_select_i} = 3'h0;
		io_addr_i = 8'h00;
		io_wdata_i = 8'h00;
		io_control_register_i = 8'h00;
		cpu_control_register_i = 8'h00;
		core_addr_i = 20'h00000;
		core_ctrl_n_i = 4'h0;
		cycle_i = 6'h00;
		wake_i = 3'h0;
		srst_i = 1'b1;
		repeat (3) @(posedge clk_sys_i);
		#10;
		srst_i = 1'b0;
		step(4);
		t_reset();
		t_marker();
		t_oneshot();
		t_halt();
		t_sleep();
		end_sim();
	end
endmodule // cmpc_top_test
